// ---- rtl/bct_pkg.sv ----
package bct_pkg;
   // register byte offsets
   localparam logic [7:0] BCT_CTRL_OFF = 8'h00;
   localparam logic [7:0] BCT_STATUS_OFF = 8'h04;
   localparam logic [7:0] BCT_TS_DIV_OFF = 8'h08;
   localparam logic [7:0] BCT_DELAY_OFF = 8'h0C;
   localparam logic [7:0] BCT_COUNT_OFF = 8'h10;
   localparam logic [7:0] BCT_INDEX_OFF = 8'h14;
   localparam logic [7:0] BCT_REC_ADDR_OFF = 8'h18;
   localparam logic [7:0] BCT_REC_CODE_OFF = 8'h1C;
   localparam logic [7:0] BCT_REC_DATA_OFF = 8'h20;
   localparam logic [7:0] BCT_REC_INFO_OFF = 8'h24;
   localparam logic [7:0] BCT_REC_TS_OFF = 8'h28;
   // field positions
   localparam int BCT_CTRL_DLY_EN_BIT = 0;
   localparam int BCT_ST_CAPT_BIT = 0;
   localparam int BCT_ST_WRAP_BIT = 1;
   localparam int BCT_ST_TRIG_BIT = 2;
   localparam int BCT_INFO_IRQ_POS = 0;
   localparam int BCT_INFO_NMI_POS = 8;
   localparam int BCT_INFO_PROBE_POS = 9;
   localparam int BCT_INFO_AREA_POS = 13;
   localparam int BCT_INFO_STATE_POS = 17;
   localparam int BCT_INFO_SIZE_POS = 20;
   localparam int BCT_INFO_WR_POS = 22;
   // reset values
   localparam logic [15:0] BCT_TS_DIV_RST = 16'h0000;
   localparam logic [15:0] BCT_DELAY_RST = 16'h0000;
   // axi responses
   localparam logic [1:0] BCT_RESP_OKAY = 2'h0;
   localparam logic [1:0] BCT_RESP_SLVERR = 2'h2;
   // access size codes
   localparam logic [1:0] BCT_SZ_BYTE = 2'h0;
   localparam logic [1:0] BCT_SZ_WORD = 2'h1;
   localparam logic [1:0] BCT_SZ_LONG = 2'h2;
   // bus state classes
   localparam logic [2:0] BCT_ST_DMA = 3'h0; // dma_controller / transfer_controller
   localparam logic [2:0] BCT_ST_DEBUG = 3'h1; // debug_port_cycle
   localparam logic [2:0] BCT_ST_BUSREL = 3'h2; // bus_released_cycle
   localparam logic [2:0] BCT_ST_DATA = 3'h3; // cpu_data_cycle
   localparam logic [2:0] BCT_ST_FETCH = 3'h4; // fetch incl. pc-relative reads
   localparam logic [2:0] BCT_ST_OTHER = 3'h5; // other_cycle
   // area classes
   localparam logic [3:0] BCT_AR_EXT32 = 4'h0; // ext_mem_32bit
   localparam logic [3:0] BCT_AR_EXT16 = 4'h1; // ext_mem_16bit
   localparam logic [3:0] BCT_AR_EXT8 = 4'h2; // ext_mem_8bit
   localparam logic [3:0] BCT_AR_EMU32 = 4'h3; // emu_mem_32bit
   localparam logic [3:0] BCT_AR_EMU16 = 4'h4; // emu_mem_16bit
   localparam logic [3:0] BCT_AR_EMU8 = 4'h5; // emu_mem_8bit
   localparam logic [3:0] BCT_AR_ROM = 4'h6;
   localparam logic [3:0] BCT_AR_IO = 4'h7;
   localparam logic [3:0] BCT_AR_RAM = 4'h8;
   // one trace record
   typedef struct packed {
      logic [31:0] addr;
      logic [15:0] instr_code_high;
      logic [15:0] instr_code_low;
      logic [31:0] data;
      logic wr;
      logic [1:0] access_size_code;
      logic [2:0] state;
      logic [3:0] area;
      logic [3:0] probe;
      logic nmi;
      logic [7:0] irq;
      logic [31:0] ts;
   } bct_rec_t;
   typedef enum logic [1:0] {RD_IDLE, RD_MEM, RD_LOAD, RD_RESP} bct_rd_t;
endpackage

// ---- rtl/bct_trace.sv ----
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - capture runs in hardware only; the target bus is never stalled
// - keep up to 128k latest records, updated while capture runs
// - when full, each new record overwrites the oldest one
// - with no qualifier every bus cycle is recorded
// - capture starts when the program runs and stops when it halts
// - readout index 0 is the newest record, older ones negative
// - with delay, the stop cycle is index 0, delay cycles positive
// - each record keeps the full 32-bit address
// - each record keeps the instruction code as two 16-bit halves
// - data is kept sized to the access: byte, word or longword
// - each record flags read or write
// - each record keeps a byte, word or longword size code
// - each record keeps one of six bus state classes
// - each record keeps one of nine memory area classes
// - each record keeps probes four down to one as four bits
// - each record keeps the nmi level of its cycle
// - each record keeps the irq levels of its cycle
// - timestamps restart from zero at every program start
// - host picks the timestamp rate, the device counts with it
module bct_trace
   import bct_pkg::*;
#(
   parameter int AW = 17
)(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic ce,
   // monitored bus
   input wire logic run,
   input wire logic cyc_valid,
   input wire logic [31:0] cyc_addr,
   input wire logic [15:0] instr_code_high,
   input wire logic [15:0] instr_code_low,
   input wire logic [31:0] cyc_data,
   input wire logic cyc_wr,
   input wire logic [1:0] access_size_code,
   input wire logic [2:0] cyc_state,
   input wire logic [3:0] cyc_area,
   input wire logic [3:0] probe,
   input wire logic nmi,
   input wire logic [7:0] irq,
   input wire logic stop_event,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [7:0] araddr;
      bct_rd_t rd_st;
      logic [AW-1:0] rd_ptr;
      logic dly_en;
      logic [15:0] ts_div;
      logic [15:0] dly_cnt;
      logic [31:0] index;
      logic run_q;
      logic capturing;
      logic wrapped;
      logic trig_seen;
      logic [AW-1:0] trig_ptr;
      logic [15:0] dly_left;
      logic [AW-1:0] wr_ptr;
      logic [AW:0] count;
      logic [15:0] presc;
      logic [31:0] ts;
   } bct_state_t;

   bct_state_t s_reg;
   bct_state_t s_next;
   bct_rec_t mem [0:(1<<AW)-1];
   bct_rec_t mem_q;
   bct_rec_t rec_in;
   logic store;

   // merge a write under byte strobes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] val,
                                         input logic [3:0] strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (old & ~m) | (val & m);
   endfunction

   // true when the offset names a register
   function automatic logic mapped(input logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= BCT_REC_TS_OFF);
   endfunction

   // record assembled from the bus; data trimmed to its size
   always_comb
   begin
      rec_in.addr = cyc_addr;
      rec_in.instr_code_high = instr_code_high;
      rec_in.instr_code_low = instr_code_low;
      case (access_size_code)
         BCT_SZ_BYTE: rec_in.data = {24'h000000, cyc_data[7:0]};
         BCT_SZ_WORD: rec_in.data = {16'h0000, cyc_data[15:0]};
         default: rec_in.data = cyc_data;
      endcase
      rec_in.wr = cyc_wr;
      rec_in.access_size_code = access_size_code;
      rec_in.state = cyc_state;
      rec_in.area = cyc_area;
      rec_in.probe = probe;
      rec_in.nmi = nmi;
      rec_in.irq = irq;
      rec_in.ts = s_reg.ts;
   end

   // every cycle seen while capturing is stored, nothing held off
   assign store = ce && s_reg.capturing && cyc_valid;

   // trace memory has no reset; write port is never blocked by readout
   always_ff @(posedge mclk)
   begin
      if (store)
      begin
         mem[s_reg.wr_ptr] <= rec_in;
      end
      if (ce)
      begin
         mem_q <= mem[s_reg.rd_ptr];
      end
   end

   // next state: capture, timestamp and bus slave
   always_comb
   begin
      logic [AW-1:0] ref_ptr;
      logic [31:0] rd_val;
      logic [31:0] wv;
      ref_ptr = '0;
      rd_val = '0;
      wv = '0;
      s_next = s_reg;
      s_next.run_q = run;
      // timestamp prescaler at the host's chosen rate
      s_next.presc = s_reg.presc + 16'h1;
      if (s_reg.presc >= s_reg.ts_div)
      begin
         s_next.presc = '0;
         s_next.ts = s_reg.ts + 32'h1;
      end
      if (store)
      begin
         s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
         if (s_reg.wr_ptr == '1)
            s_next.wrapped = 1'b1;
         if (!s_reg.count[AW])
            s_next.count = s_reg.count + 1'b1;
         if (stop_event && s_reg.dly_en && !s_reg.trig_seen)
         begin
            s_next.trig_seen = 1'b1;
            s_next.trig_ptr = s_reg.wr_ptr;
            s_next.dly_left = s_reg.dly_cnt;
            if (s_reg.dly_cnt == 16'h0)
               s_next.capturing = 1'b0;
         end
         else if (s_reg.trig_seen)
         begin
            s_next.dly_left = s_reg.dly_left - 16'h1;
            if (s_reg.dly_left <= 16'h1)
               s_next.capturing = 1'b0;
         end
      end
      // program start clears the store and timestamp
      if (run && !s_reg.run_q)
      begin
         s_next.capturing = 1'b1;
         s_next.ts = '0;
         s_next.presc = '0;
         s_next.wr_ptr = '0;
         s_next.count = '0;
         s_next.wrapped = 1'b0;
         s_next.trig_seen = 1'b0;
      end
      else if (!run && s_reg.run_q)
         s_next.capturing = 1'b0;
      // write channel: address and data taken in either order
      if (s_reg.awready && s_axi_awvalid)
      begin
         s_next.aw_got = 1'b1;
         s_next.awaddr = s_axi_awaddr;
      end
      if (s_reg.wready && s_axi_wvalid)
      begin
         s_next.w_got = 1'b1;
         s_next.wdata = s_axi_wdata;
         s_next.wstrb = s_axi_wstrb;
      end
      if (s_reg.bvalid && s_axi_bready)
         s_next.bvalid = 1'b0;
      if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid)
      begin
         s_next.aw_got = 1'b0;
         s_next.w_got = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = BCT_RESP_OKAY;
         case (s_reg.awaddr)
            BCT_CTRL_OFF:
            begin
               wv = merge({31'h0, s_reg.dly_en}, s_reg.wdata, s_reg.wstrb);
               s_next.dly_en = wv[BCT_CTRL_DLY_EN_BIT];
            end
            BCT_TS_DIV_OFF:
            begin
               wv = merge({16'h0, s_reg.ts_div}, s_reg.wdata, s_reg.wstrb);
               s_next.ts_div = wv[15:0];
            end
            BCT_DELAY_OFF:
            begin
               wv = merge({16'h0, s_reg.dly_cnt}, s_reg.wdata, s_reg.wstrb);
               s_next.dly_cnt = wv[15:0];
            end
            BCT_INDEX_OFF:
            begin
               s_next.index = merge(s_reg.index, s_reg.wdata, s_reg.wstrb);
            end
            default:
            begin
               if (!mapped(s_reg.awaddr))
                  s_next.bresp = BCT_RESP_SLVERR;
            end
         endcase
      end
      s_next.awready = !s_next.aw_got && !s_next.bvalid;
      s_next.wready = !s_next.w_got && !s_next.bvalid;
      // read: index is relative to the newest or the stop record
      ref_ptr = s_reg.trig_seen ? s_reg.trig_ptr : s_reg.wr_ptr - 1'b1;
      s_next.arready = 1'b0;
      case (s_reg.rd_st)
         RD_IDLE:
         begin
            s_next.arready = 1'b1;
            if (s_reg.arready && s_axi_arvalid)
            begin
               s_next.arready = 1'b0;
               s_next.araddr = s_axi_araddr;
               s_next.rd_ptr = ref_ptr + s_reg.index[AW-1:0];
               s_next.rd_st = RD_MEM;
            end
         end
         RD_MEM: s_next.rd_st = RD_LOAD;
         RD_LOAD:
         begin
            case (s_reg.araddr)
               BCT_CTRL_OFF: rd_val = {31'h0, s_reg.dly_en};
               BCT_STATUS_OFF:
               begin
                  rd_val[BCT_ST_CAPT_BIT] = s_reg.capturing;
                  rd_val[BCT_ST_WRAP_BIT] = s_reg.wrapped;
                  rd_val[BCT_ST_TRIG_BIT] = s_reg.trig_seen;
               end
               BCT_TS_DIV_OFF: rd_val = {16'h0, s_reg.ts_div};
               BCT_DELAY_OFF: rd_val = {16'h0, s_reg.dly_cnt};
               BCT_COUNT_OFF: rd_val = 32'(s_reg.count);
               BCT_INDEX_OFF: rd_val = s_reg.index;
               BCT_REC_ADDR_OFF: rd_val = mem_q.addr;
               BCT_REC_CODE_OFF:
                  rd_val = {mem_q.instr_code_high, mem_q.instr_code_low};
               BCT_REC_DATA_OFF: rd_val = mem_q.data;
               BCT_REC_INFO_OFF:
               begin
                  rd_val[BCT_INFO_IRQ_POS +: 8] = mem_q.irq;
                  rd_val[BCT_INFO_NMI_POS] = mem_q.nmi;
                  rd_val[BCT_INFO_PROBE_POS +: 4] = mem_q.probe;
                  rd_val[BCT_INFO_AREA_POS +: 4] = mem_q.area;
                  rd_val[BCT_INFO_STATE_POS +: 3] = mem_q.state;
                  rd_val[BCT_INFO_SIZE_POS +: 2] = mem_q.access_size_code;
                  rd_val[BCT_INFO_WR_POS] = mem_q.wr;
               end
               BCT_REC_TS_OFF: rd_val = mem_q.ts;
               default: rd_val = '0;
            endcase
            s_next.rdata = rd_val;
            s_next.rresp = mapped(s_reg.araddr) ? BCT_RESP_OKAY
                                                : BCT_RESP_SLVERR;
            s_next.rvalid = 1'b1;
            s_next.rd_st = RD_RESP;
         end
         RD_RESP:
         begin
            if (s_axi_rready)
            begin
               s_next.rvalid = 1'b0;
               s_next.arready = 1'b1;
               s_next.rd_st = RD_IDLE;
            end
         end
         default: s_next.rd_st = RD_IDLE;
      endcase
   end

   // state register; low ce freezes everything
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_reg <= '0;
         s_reg.ts_div <= BCT_TS_DIV_RST;
         s_reg.dly_cnt <= BCT_DELAY_RST;
         s_reg.rd_st <= RD_IDLE;
      end
      else if (ce)
      begin
         s_reg <= s_next;
      end
   end

   // outputs straight from the state register
   assign s_axi_awready = s_reg.awready;
   assign s_axi_wready = s_reg.wready;
   assign s_axi_bvalid = s_reg.bvalid;
   assign s_axi_bresp = s_reg.bresp;
   assign s_axi_arready = s_reg.arready;
   assign s_axi_rvalid = s_reg.rvalid;
   assign s_axi_rresp = s_reg.rresp;
   assign s_axi_rdata = s_reg.rdata;

   // checks
   halt_stops_capture_a: assert property (
      @(posedge mclk) disable iff (!arst_n)
      ce && !run && s_reg.run_q |=> !s_reg.capturing)
      else $error("capture still on after halt");
   start_clears_ts_a: assert property (
      @(posedge mclk) disable iff (!arst_n)
      ce && run && !s_reg.run_q |=> s_reg.ts == 32'h0 && s_reg.capturing)
      else $error("timestamp not restarted at run");
   ptr_steps_one_a: assert property (
      @(posedge mclk) disable iff (!arst_n)
      store && !(run && !s_reg.run_q)
      |=> s_reg.wr_ptr == $past(s_reg.wr_ptr) + 1'b1)
      else $error("write pointer did not step by one");
   ptr_holds_idle_a: assert property (
      @(posedge mclk) disable iff (!arst_n)
      ce && !store && !(run && !s_reg.run_q) |=> $stable(s_reg.wr_ptr))
      else $error("write pointer moved without a record");
   wrap_marks_full_a: assert property (
      @(posedge mclk) disable iff (!arst_n)
      store && s_reg.wr_ptr == '1 && !(run && !s_reg.run_q)
      |=> s_reg.wrapped && s_reg.wr_ptr == '0)
      else $error("buffer did not wrap");
   every_cycle_kept_a: assert property (
      @(posedge mclk) disable iff (!arst_n)
      ce && s_reg.capturing && cyc_valid && !(run && !s_reg.run_q)
      |=> s_reg.wr_ptr != $past(s_reg.wr_ptr))
      else $error("bus cycle dropped");
   byte_data_trim_a: assert property (
      @(posedge mclk) disable iff (!arst_n)
      access_size_code == BCT_SZ_BYTE |-> rec_in.data[31:8] == 24'h0)
      else $error("byte data not trimmed");
   zero_delay_stop_a: assert property (
      @(posedge mclk) disable iff (!arst_n)
      store && stop_event && s_reg.dly_en && !s_reg.trig_seen
      && s_reg.dly_cnt == 16'h0 && !(run && !s_reg.run_q)
      |=> !s_reg.capturing && s_reg.trig_ptr == $past(s_reg.wr_ptr))
      else $error("stop record not fixed at index zero");
   read_latency_a: assert property (
      @(posedge mclk) disable iff (!arst_n)
      ce && s_axi_arvalid && s_axi_arready ##1 ce [*2] |=> s_axi_rvalid)
      else $error("read answer late");
endmodule
`default_nettype wire

// ---- testbench/bct_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// target bus as the monitor sees it: one completed cycle per valid pulse
module bct_bus_model
   import bct_pkg::*;
(
   input wire logic mclk,
   output logic run,
   output logic cyc_valid,
   output logic [31:0] cyc_addr,
   output logic [15:0] instr_code_high,
   output logic [15:0] instr_code_low,
   output logic [31:0] cyc_data,
   output logic cyc_wr,
   output logic [1:0] access_size_code,
   output logic [2:0] cyc_state,
   output logic [3:0] cyc_area,
   output logic [3:0] probe,
   output logic nmi,
   output logic [7:0] irq,
   output logic stop_event
);
   bct_rec_t p = '0;
   int k = 0;
   initial
   begin
      run = 1'b0;
      cyc_valid = 1'b0;
      stop_event = 1'b0;
   end
   // payload lines follow the held record, timestamp bits excluded
   assign {cyc_addr, instr_code_high, instr_code_low, cyc_data, cyc_wr,
      access_size_code, cyc_state, cyc_area, probe, nmi, irq} =
      p[$bits(bct_rec_t)-1:32];
   // payload of cycle n; fields differ so a swapped field shows up
   function automatic bct_rec_t pay(input int n);
      bct_rec_t r;
      logic [15:0] m;
      m = n[15:0];
      r = '0;
      r.addr = {16'hA5C3, m};
      r.instr_code_high = ~m;
      r.instr_code_low = m ^ 16'h5A5A;
      r.data = {m ^ 16'h0F0F, ~m};
      r.wr = m[0];
      r.access_size_code = 2'(n % 3);
      r.state = 3'(n % 6);
      r.area = 4'(n % 9);
      r.probe = m[4:1];
      r.nmi = m[1];
      r.irq = m[7:0] ^ 8'hC3;
      return r;
   endfunction
   // the target never waits on the tracer: no ready exists
   task automatic set_run(input logic b);
      @(posedge mclk);
      run <= b;
      if (b)
         k = 0;
   endtask
   // released bus inverts the pattern on each idle clock; a second idle clock in a row shows the last value
   task automatic idle();
      @(posedge mclk);
      cyc_valid <= 1'b0;
      stop_event <= 1'b0;
      p <= ~p;
   endtask
   task automatic cycles(input int n, input int gap, input int stop_at);
      repeat (n)
      begin
         @(posedge mclk);
         cyc_valid <= 1'b1;
         p <= pay(k);
         stop_event <= (k == stop_at);
         k++;
         repeat (gap) idle();
      end
      idle();
   endtask
endmodule
`default_nettype wire

// ---- testbench/bct_trace_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module bct_trace_tb
   import bct_pkg::*;
;
   typedef struct {int idx; int n;} bct_row_t;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic ce = 1'b1;
   logic run, cyc_valid, cyc_wr, nmi, stop_event;
   logic [31:0] cyc_addr, cyc_data, s_axi_rdata, d, t0, t1, t2;
   logic [15:0] instr_code_high, instr_code_low;
   logic [1:0] access_size_code, s_axi_bresp, s_axi_rresp;
   logic [2:0] cyc_state;
   logic [3:0] cyc_area, probe;
   logic [7:0] irq;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   int error_cnt = 0;
   int comparisons = 0;
   // newest record is 0, older ones count down
   bct_row_t rows[4] = '{'{0, 9}, '{-1, 8}, '{-4, 5}, '{-9, 0}};
   // small store so that wrapping is cheap to reach
   bct_trace #(.AW(4)) bct_trace_i (.mclk, .arst_n, .ce, .run, .cyc_valid,
      .cyc_addr, .instr_code_high, .instr_code_low, .cyc_data, .cyc_wr,
      .access_size_code, .cyc_state, .cyc_area, .probe, .nmi, .irq,
      .stop_event, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   bct_bus_model bct_bus_model_i (.mclk, .run, .cyc_valid, .cyc_addr,
      .instr_code_high, .instr_code_low, .cyc_data, .cyc_wr,
      .access_size_code, .cyc_state, .cyc_area, .probe, .nmi, .irq,
      .stop_event);
   initial
   begin
      forever #50 mclk = ~mclk;
   end
   task automatic close_out();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // write: address and data offered together, each dropped when taken
   task automatic axw(input logic [7:0] a, input logic [31:0] v,
                      input logic [1:0] er);
      logic done;
      done = 1'b0;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done)
      begin
         @(posedge mclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
         begin
            done = 1'b1;
            s_axi_bready <= 1'b0;
            chk({30'h0, s_axi_bresp}, {30'h0, er});
         end
      end
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] v,
                      input logic [1:0] er);
      logic done;
      done = 1'b0;
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done)
      begin
         @(posedge mclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
         begin
            done = 1'b1;
            v = s_axi_rdata;
            s_axi_rready <= 1'b0;
            chk({30'h0, s_axi_rresp}, {30'h0, er});
         end
      end
   endtask
   // select a record, then compare every field with cycle n's payload
   task automatic rec(input int idx, input int n);
      bct_rec_t e;
      logic [31:0] v;
      e = bct_bus_model_i.pay(n);
      axw(BCT_INDEX_OFF, 32'(idx), BCT_RESP_OKAY);
      axr(BCT_REC_ADDR_OFF, v, BCT_RESP_OKAY);
      chk(v, e.addr);
      axr(BCT_REC_CODE_OFF, v, BCT_RESP_OKAY);
      chk(v, {e.instr_code_high, e.instr_code_low});
      axr(BCT_REC_DATA_OFF, v, BCT_RESP_OKAY);
      chk(v, e.access_size_code == BCT_SZ_BYTE ? {24'h0, e.data[7:0]} :
         e.access_size_code == BCT_SZ_WORD ? {16'h0, e.data[15:0]} :
         e.data);
      axr(BCT_REC_INFO_OFF, v, BCT_RESP_OKAY);
      chk(v, {9'h0, e.wr, e.access_size_code, e.state, e.area, e.probe,
         e.nmi, e.irq});
   endtask
   // watchdog at 30000 clocks: the whole sequence needs well under that
   initial
   begin
      #(100 * 30000);
      error_cnt++;
      close_out();
   end
   initial
   begin
      repeat (3) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      axr(BCT_TS_DIV_OFF, d, BCT_RESP_OKAY);
      chk(d, {16'h0, BCT_TS_DIV_RST});
      axr(BCT_DELAY_OFF, d, BCT_RESP_OKAY);
      chk(d, {16'h0, BCT_DELAY_RST});
      axr(8'h40, d, BCT_RESP_SLVERR);
      chk(d, 32'h0);
      axr(8'h02, d, BCT_RESP_SLVERR);
      chk(d, 32'h0);
      // free run of ten back-to-back cycles, then cycles after halt
      bct_bus_model_i.set_run(1'b1);
      bct_bus_model_i.cycles(10, 0, -1);
      bct_bus_model_i.set_run(1'b0);
      bct_bus_model_i.cycles(3, 0, -1);
      axr(BCT_COUNT_OFF, d, BCT_RESP_OKAY);
      chk(d, 32'd10);
      axw(BCT_COUNT_OFF, 32'h0, BCT_RESP_OKAY);
      axr(BCT_COUNT_OFF, d, BCT_RESP_OKAY);
      chk(d, 32'd10);
      axr(BCT_STATUS_OFF, d, BCT_RESP_OKAY);
      chk(d, 32'h0);
      foreach (rows[i]) rec(rows[i].idx, rows[i].n);
      // twenty cycles into sixteen entries: oldest four overwritten
      bct_bus_model_i.set_run(1'b1);
      bct_bus_model_i.cycles(20, 0, -1);
      axr(BCT_STATUS_OFF, d, BCT_RESP_OKAY);
      chk(d, 32'h3);
      bct_bus_model_i.set_run(1'b0);
      axr(BCT_COUNT_OFF, d, BCT_RESP_OKAY);
      chk(d, 32'd16);
      rec(0, 19);
      rec(-15, 4);
      // stop at cycle five, three delay records follow it
      axw(BCT_CTRL_OFF, 32'h1, BCT_RESP_OKAY);
      axw(BCT_DELAY_OFF, 32'h3, BCT_RESP_OKAY);
      bct_bus_model_i.set_run(1'b1);
      bct_bus_model_i.cycles(12, 0, 5);
      axr(BCT_STATUS_OFF, d, BCT_RESP_OKAY);
      chk(d, 32'h4);
      axr(BCT_COUNT_OFF, d, BCT_RESP_OKAY);
      chk(d, 32'd9);
      rec(0, 5);
      rec(3, 8);
      rec(-5, 0);
      bct_bus_model_i.set_run(1'b0);
      // only byte lane one written: the low byte of the delay stays
      s_axi_wstrb <= 4'h2;
      axw(BCT_DELAY_OFF, 32'h0000_AB77, BCT_RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      axr(BCT_DELAY_OFF, d, BCT_RESP_OKAY);
      chk(d, 32'h0000_AB03);
      // ticks every two clocks, cycles every two clocks: step of one
      axw(BCT_CTRL_OFF, 32'h0, BCT_RESP_OKAY);
      axw(BCT_TS_DIV_OFF, 32'h1, BCT_RESP_OKAY);
      bct_bus_model_i.set_run(1'b1);
      bct_bus_model_i.cycles(3, 1, -1);
      bct_bus_model_i.set_run(1'b0);
      axw(BCT_INDEX_OFF, 32'h0, BCT_RESP_OKAY);
      axr(BCT_REC_TS_OFF, t0, BCT_RESP_OKAY);
      axw(BCT_INDEX_OFF, 32'hFFFF_FFFF, BCT_RESP_OKAY);
      axr(BCT_REC_TS_OFF, t1, BCT_RESP_OKAY);
      axw(BCT_INDEX_OFF, 32'hFFFF_FFFE, BCT_RESP_OKAY);
      axr(BCT_REC_TS_OFF, t2, BCT_RESP_OKAY);
      chk(t0 - t1, 32'h1);
      chk(t1 - t2, 32'h1);
      chk(t2, 32'h0);
      // ce low freezes all state: cycles offered then are not kept
      bct_bus_model_i.set_run(1'b1);
      @(posedge mclk);
      ce <= 1'b0;
      bct_bus_model_i.cycles(2, 0, -1);
      ce <= 1'b1;
      bct_bus_model_i.cycles(3, 0, -1);
      bct_bus_model_i.set_run(1'b0);
      axr(BCT_COUNT_OFF, d, BCT_RESP_OKAY);
      chk(d, 32'd3);
      rec(0, 4);
      rec(-2, 2);
      close_out();
   end
endmodule
`default_nettype wire
